// *** logic/dpr_cfg.svh ***
// Timing and geometry constants for the dual-port RAM port controller.
// Assumes a 100 MHz system clock; all pin timings are rounded up to cycles.
`ifndef DPR_CFG_SVH
`define DPR_CFG_SVH

// Geometry of one port of the RAM.
`define DPR_AW            13
`define DPR_DW            8
`define DPR_SEM_IDX_LAST  3'h7

// Clock period and pin timings in nanoseconds.
`define DPR_CLK_NS        10
`define DPR_T_ACCESS_NS   55
`define DPR_T_FLOW_NS     55
`define DPR_T_WPULSE_NS   40
`define DPR_T_HOLD_NS     10
`define DPR_T_BUSY_NS     45
`define DPR_T_SOP_NS      20

// Least times round up to whole cycles, never below one.
`define DPR_CYC(ns) ((((ns) + `DPR_CLK_NS - 1) / `DPR_CLK_NS) < 1 ? 1 : \
                     (((ns) + `DPR_CLK_NS - 1) / `DPR_CLK_NS))

// Two flip-flops of input synchronisation delay.
`define DPR_SYNC_CYC      2

// Semaphore data values on the lowest data line.
`define DPR_SEM_TAKE_BIT  1'h0
`define DPR_SEM_FREE_BIT  1'h1

`endif

// *** logic/dpr_pkg.sv ***
// Types shared by the dual-port RAM port controller.
// Assumes dpr_cfg.svh sets the address and data widths.
`include "dpr_cfg.svh"

package dpr_pkg;

    // Operations that the user side can request.
    typedef enum logic [2:0] {
        DPR_OP_RD       = 3'h0,
        DPR_OP_WR       = 3'h1,
        DPR_OP_SEM_RD   = 3'h2,
        DPR_OP_SEM_TAKE = 3'h3,
        DPR_OP_SEM_GIVE = 3'h4,
        DPR_OP_SEM_INIT = 3'h5
    } dpr_op_t;

    // One request from the user side.
    typedef struct packed {
        dpr_op_t               op;
        logic [`DPR_AW-1:0]    addr;
        logic [`DPR_DW-1:0]    data;
    } dpr_cmd_t;

    // One answer to the user side.
    typedef struct packed {
        logic [`DPR_DW-1:0]    data;
        logic                  granted;
        logic                  timeout;
    } dpr_rsp_t;

    // Sequencer states.
    typedef enum logic [2:0] {
        DPR_ST_IDLE   = 3'h0,
        DPR_ST_ARM    = 3'h1,
        DPR_ST_WBUSY  = 3'h2,
        DPR_ST_STROBE = 3'h3,
        DPR_ST_HOLD   = 3'h4,
        DPR_ST_GAP    = 3'h5,
        DPR_ST_READ   = 3'h6
    } dpr_state_t;

endpackage : dpr_pkg

// *** logic/dpr_sync.sv ***
// Two-flop synchroniser for pin inputs of the dual-port RAM controller.
// Assumes inputs are asynchronous to i_sys_clk.
`timescale 1ns/1ps
`default_nettype none

module dpr_sync #(
    parameter int W = 1
) (
    // Clock, reset and enable.
    input  wire logic          i_sys_clk,
    input  wire logic          i_rst_b,
    input  wire logic          i_clk_en,
    // Raw and synchronised levels.
    input  wire logic [W-1:0]  i_d,
    output logic      [W-1:0]  o_q
);

    logic [W-1:0] meta;

    // The first stage feeds only the second, to let metastability settle.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            meta <= '1;
            o_q  <= '1;
        end else if (i_clk_en) begin
            meta <= i_d;
            o_q  <= meta;
        end
    end

endmodule : dpr_sync

`default_nettype wire

// *** logic/dpr_port_ctrl.sv ***
// Host-side controller that drives one port of a dual-port static RAM.
// Assumes the RAM pins are asynchronous and all pin inputs are synchronised.
// Contract
// - Write: select low, semaphore high, strobe low.
// - Reader waits flowthrough delay after other write.
// - Read needs select and output gate low.
// - Semaphore select replaces array select, never both.
// - Slave writes wait for settled busy input.
// - Write zero, deselect, read back, poll on one.
// - Software frees every semaphore at start.
`timescale 1ns/1ps
`default_nettype none
`include "dpr_cfg.svh"

module dpr_port_ctrl #(
    parameter int POLL_MAX = 16
) (
    // Clock, reset and enable.
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_rst_b,
    input  wire logic                   i_clk_en,
    // User request and answer.
    input  wire logic                   i_cmd_valid,
    input  wire dpr_pkg::dpr_cmd_t      i_cmd,
    output logic                        o_cmd_ready,
    output logic                        o_rsp_valid,
    output dpr_pkg::dpr_rsp_t           o_rsp,
    // Status seen on the RAM's flag pins.
    output logic                        o_mbox_flag,
    output logic                        o_busy_hit,
    // RAM pins.
    output logic                        o_ce_b,
    output logic                        o_sem_b,
    output logic                        o_we_b,
    output logic                        o_oe_b,
    output logic [`DPR_AW-1:0]          o_addr,
    input  wire logic [`DPR_DW-1:0]     i_dq,
    output logic [`DPR_DW-1:0]          o_dq,
    output logic                        o_dq_oe,
    input  wire logic                   i_int_b,
    input  wire logic                   i_busy_b
);

    localparam logic [7:0] ACC_CYC  = 8'(`DPR_CYC(`DPR_T_ACCESS_NS)
                                      + `DPR_CYC(`DPR_T_FLOW_NS)
                                      + `DPR_SYNC_CYC);
    localparam logic [7:0] WP_CYC   = 8'(`DPR_CYC(`DPR_T_WPULSE_NS));
    localparam logic [7:0] HOLD_CYC = 8'(`DPR_CYC(`DPR_T_HOLD_NS));
    localparam logic [7:0] BSY_CYC  = 8'(`DPR_CYC(`DPR_T_BUSY_NS)
                                      + `DPR_SYNC_CYC);
    localparam logic [7:0] SOP_CYC  = 8'(`DPR_CYC(`DPR_T_SOP_NS));
    localparam logic [7:0] POLL_LIM = 8'(POLL_MAX);

    dpr_pkg::dpr_state_t  state;
    dpr_pkg::dpr_op_t     op;
    logic [7:0]           cnt;
    logic [7:0]           polls;
    logic [2:0]           sem_idx;
    logic [`DPR_DW-1:0]   dq_sync;
    logic                 int_sync;
    logic                 busy_sync;

    // Flags and read data all come from pins, so they cross two flops.
    dpr_sync #(
        .W (`DPR_DW + 2)
    ) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_rst_b   (i_rst_b),
        .i_clk_en  (i_clk_en),
        .i_d       ({i_int_b, i_busy_b, i_dq}),
        .o_q       ({int_sync, busy_sync, dq_sync})
    );

    // True for the semaphore operations that write the lowest data line.
    function automatic logic is_sem_wr(input dpr_pkg::dpr_op_t o);
        is_sem_wr = (o == dpr_pkg::DPR_OP_SEM_TAKE) ||
                    (o == dpr_pkg::DPR_OP_SEM_GIVE) ||
                    (o == dpr_pkg::DPR_OP_SEM_INIT);
    endfunction : is_sem_wr

    // Flag pins are shown to the user as active-high levels.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_mbox_flag <= 1'h0;
            o_busy_hit  <= 1'h0;
        end else if (i_clk_en) begin
            o_mbox_flag <= ~int_sync;
            o_busy_hit  <= ~busy_sync;
        end
    end

    // Access sequencer; every pin changes only on a clock edge.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            state       <= dpr_pkg::DPR_ST_IDLE;
            op          <= dpr_pkg::DPR_OP_RD;
            cnt         <= 8'h00;
            polls       <= 8'h00;
            sem_idx     <= 3'h0;
            o_cmd_ready <= 1'h1;
            o_rsp_valid <= 1'h0;
            o_rsp       <= '0;
            o_ce_b      <= 1'h1;
            o_sem_b     <= 1'h1;
            o_we_b      <= 1'h1;
            o_oe_b      <= 1'h1;
            o_addr      <= '0;
            o_dq        <= '0;
            o_dq_oe     <= 1'h0;
        end else if (i_clk_en) begin
            o_rsp_valid <= 1'h0;
            case (state)
                dpr_pkg::DPR_ST_IDLE: begin
                    polls   <= 8'h00;
                    sem_idx <= 3'h0;
                    if (i_cmd_valid) begin
                        op          <= i_cmd.op;
                        o_cmd_ready <= 1'h0;
                        o_addr      <= i_cmd.addr;
                        if (i_cmd.op == dpr_pkg::DPR_OP_WR) begin
                            o_ce_b  <= 1'h0;
                            o_dq    <= i_cmd.data;
                            o_dq_oe <= 1'h1;
                            cnt     <= BSY_CYC;
                            state   <= dpr_pkg::DPR_ST_ARM;
                        end else if (is_sem_wr(i_cmd.op)) begin
                            // Semaphore select stands in for array select.
                            o_sem_b <= 1'h0;
                            o_we_b  <= 1'h0;
                            o_dq    <= {`DPR_DW{
                                (i_cmd.op == dpr_pkg::DPR_OP_SEM_TAKE)
                                ? `DPR_SEM_TAKE_BIT
                                : `DPR_SEM_FREE_BIT}};
                            o_dq_oe <= 1'h1;
                            if (i_cmd.op == dpr_pkg::DPR_OP_SEM_INIT) begin
                                o_addr <= '0;
                            end
                            cnt     <= WP_CYC;
                            state   <= dpr_pkg::DPR_ST_STROBE;
                        end else begin
                            o_ce_b  <= (i_cmd.op != dpr_pkg::DPR_OP_RD);
                            o_sem_b <= (i_cmd.op == dpr_pkg::DPR_OP_RD);
                            o_oe_b  <= 1'h0;
                            cnt     <= ACC_CYC;
                            state   <= dpr_pkg::DPR_ST_READ;
                        end
                    end
                end
                dpr_pkg::DPR_ST_ARM: begin
                    // Let the busy answer of the arbiter settle first.
                    if (cnt > 8'h01) begin
                        cnt <= cnt - 8'h01;
                    end else begin
                        state <= dpr_pkg::DPR_ST_WBUSY;
                    end
                end
                dpr_pkg::DPR_ST_WBUSY: begin
                    // A write never starts while the other port holds it.
                    if (busy_sync) begin
                        o_we_b <= 1'h0;
                        cnt    <= WP_CYC;
                        state  <= dpr_pkg::DPR_ST_STROBE;
                    end
                end
                dpr_pkg::DPR_ST_STROBE: begin
                    if (cnt > 8'h01) begin
                        cnt <= cnt - 8'h01;
                    end else begin
                        // Data is captured on this rising strobe edge.
                        o_we_b <= 1'h1;
                        cnt    <= HOLD_CYC;
                        state  <= dpr_pkg::DPR_ST_HOLD;
                    end
                end
                dpr_pkg::DPR_ST_HOLD: begin
                    if (cnt > 8'h01) begin
                        cnt <= cnt - 8'h01;
                    end else begin
                        o_ce_b  <= 1'h1;
                        o_sem_b <= 1'h1;
                        o_dq_oe <= 1'h0;
                        cnt     <= SOP_CYC;
                        if (op == dpr_pkg::DPR_OP_SEM_TAKE) begin
                            state <= dpr_pkg::DPR_ST_GAP;
                        end else if (op == dpr_pkg::DPR_OP_SEM_INIT &&
                                     sem_idx != `DPR_SEM_IDX_LAST) begin
                            sem_idx <= sem_idx + 3'h1;
                            state   <= dpr_pkg::DPR_ST_GAP;
                        end else begin
                            o_rsp       <= '0;
                            o_rsp_valid <= 1'h1;
                            o_cmd_ready <= 1'h1;
                            state       <= dpr_pkg::DPR_ST_IDLE;
                        end
                    end
                end
                dpr_pkg::DPR_ST_GAP: begin
                    // Semaphore select stays high between one semaphore access and the next.
                    if (cnt > 8'h01) begin
                        cnt <= cnt - 8'h01;
                    end else if (op == dpr_pkg::DPR_OP_SEM_INIT) begin
                        o_addr  <= {{(`DPR_AW-3){1'h0}}, sem_idx};
                        o_sem_b <= 1'h0;
                        o_we_b  <= 1'h0;
                        o_dq_oe <= 1'h1;
                        cnt     <= WP_CYC;
                        state   <= dpr_pkg::DPR_ST_STROBE;
                    end else begin
                        o_sem_b <= 1'h0;
                        o_oe_b  <= 1'h0;
                        cnt     <= ACC_CYC;
                        state   <= dpr_pkg::DPR_ST_READ;
                    end
                end
                dpr_pkg::DPR_ST_READ: begin
                    // The wait covers access, flowthrough and the synchroniser.
                    if (cnt > 8'h01) begin
                        cnt <= cnt - 8'h01;
                    end else begin
                        o_ce_b  <= 1'h1;
                        o_sem_b <= 1'h1;
                        o_oe_b  <= 1'h1;
                        if (op == dpr_pkg::DPR_OP_SEM_TAKE &&
                            dq_sync[0] != `DPR_SEM_TAKE_BIT &&
                            polls != POLL_LIM) begin
                            // Other port owns it: poll again after a gap.
                            polls <= polls + 8'h01;
                            cnt   <= SOP_CYC;
                            state <= dpr_pkg::DPR_ST_GAP;
                        end else begin
                            o_rsp.data    <= dq_sync;
                            o_rsp.granted <= (op == dpr_pkg::DPR_OP_SEM_TAKE)
                                && (dq_sync[0] == `DPR_SEM_TAKE_BIT);
                            o_rsp.timeout <= (op == dpr_pkg::DPR_OP_SEM_TAKE)
                                && (dq_sync[0] != `DPR_SEM_TAKE_BIT);
                            o_rsp_valid   <= 1'h1;
                            o_cmd_ready   <= 1'h1;
                            state         <= dpr_pkg::DPR_ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= dpr_pkg::DPR_ST_IDLE;
                end
            endcase
        end
    end

    default clocking dpr_cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_b);

    sel_excl_a: assert property (o_ce_b || o_sem_b)
        else $error("array and semaphore selects low together");

    wr_data_a: assert property (
        (!o_we_b && $past(!o_we_b)) |-> o_dq_oe && $stable(o_dq))
        else $error("write data moved while strobe low");

    wr_sel_a: assert property (
        (!o_we_b && !o_ce_b) |-> o_sem_b && o_dq_oe)
        else $error("array write without proper selects");

    rd_gate_a: assert property (
        !o_oe_b |-> o_we_b && !o_dq_oe && !(o_ce_b && o_sem_b))
        else $error("read gate without select or with drive");

    rd_wait_a: assert property (
        $fell(o_oe_b) |-> (!o_oe_b)[*8])
        else $error("read ended before flowthrough wait");

    wr_busy_a: assert property (
        ($fell(o_we_b) && !o_ce_b)
        |-> $past(busy_sync) && $past(o_ce_b, 3) == 1'h0)
        else $error("write started without settled busy");

    sem_gap_a: assert property (
        ($fell(o_oe_b) && !o_sem_b && op == dpr_pkg::DPR_OP_SEM_TAKE)
        |-> $past(o_sem_b) && $past(o_sem_b, 2))
        else $error("semaphore read without deselect gap");

    take_rsp_a: assert property (
        (o_rsp_valid && o_rsp.granted) |-> $past(dq_sync[0]) == 1'h0
        && op == dpr_pkg::DPR_OP_SEM_TAKE)
        else $error("grant reported without a zero read");

    idle_pins_a: assert property (
        (state == dpr_pkg::DPR_ST_IDLE) |->
        o_ce_b && o_sem_b && o_we_b && o_oe_b && !o_dq_oe)
        else $error("pins active while idle");

endmodule : dpr_port_ctrl

`default_nettype wire

// *** dv/dpr_ram_model.sv ***
// Behavioural model of the two-port static RAM seen by the port controller.
// Assumes the left port is wired to the controller and the right port to
// the bench; the model is set as master, so its busy lines are outputs.
`timescale 1ns/1ps
`default_nettype none
`include "dpr_cfg.svh"

module dpr_ram_model (
    // Clock used only to pace the floating data pattern.
    input  wire logic                i_sys_clk,
    // Left port pins.
    input  wire logic                i_l_ce_b,
    input  wire logic                i_l_sem_b,
    input  wire logic                i_l_we_b,
    input  wire logic                i_l_oe_b,
    input  wire logic [`DPR_AW-1:0]  i_l_addr,
    input  wire logic [`DPR_DW-1:0]  i_l_dq,
    input  wire logic                i_l_dq_oe,
    output logic      [`DPR_DW-1:0]  o_l_dq,
    output logic                     o_l_int_b,
    output logic                     o_l_busy_b,
    // Right port pins.
    input  wire logic                i_r_ce_b,
    input  wire logic                i_r_sem_b,
    input  wire logic                i_r_we_b,
    input  wire logic                i_r_oe_b,
    input  wire logic [`DPR_AW-1:0]  i_r_addr,
    input  wire logic [`DPR_DW-1:0]  i_r_din,
    output logic      [`DPR_DW-1:0]  o_r_dq,
    output logic                     o_r_int_b,
    output logic                     o_r_busy_b
);
    logic [`DPR_DW-1:0] mem [0:8191];
    logic [1:0]         own [0:7];   // 0 free, 1 left, 2 right.
    logic [7:0]         req [1:2];
    logic [`DPR_DW-1:0] sreg_l;
    logic [`DPR_DW-1:0] sreg_r;
    logic [`DPR_DW-1:0] last_l;
    logic               int_l;
    logic               int_r;
    realtime            t_l;
    realtime            t_r;
    wire match = !i_l_ce_b && !i_r_ce_b && (i_l_addr == i_r_addr);
    wire l_ard = !i_l_ce_b && i_l_sem_b && !i_l_oe_b && i_l_we_b;
    wire l_srd = i_l_ce_b && !i_l_sem_b && !i_l_oe_b && i_l_we_b;
    wire r_ard = !i_r_ce_b && i_r_sem_b && !i_r_oe_b && i_r_we_b;
    wire r_srd = i_r_ce_b && !i_r_sem_b && !i_r_oe_b && i_r_we_b;

    // Latches are not cleared at power up, so start them split between ports.
    initial begin
        for (int i = 0; i < 8; i++) own[i] = i[0] ? 2'h2 : 2'h1;
        req[1] = 8'h00;
        req[2] = 8'h00;
        int_l = 1'h1;
        int_r = 1'h1;
        last_l = 8'h00;
        t_l = 0;
        t_r = 0;
    end

    // Semaphore write by port p; event order settles simultaneous requests.
    task automatic sem_wr(input int p, input logic [2:0] i, input logic v);
        int o;
        o = 3 - p;
        if (!v) begin
            if (own[i] == 2'h0) own[i] = 2'(p);
            else if (own[i] != 2'(p)) req[p][i] = 1'h1;
        end else begin
            if (own[i] == 2'(p)) begin
                own[i] = req[o][i] ? 2'(o) : 2'h0;
                req[o][i] = 1'h0;
            end
            req[p][i] = 1'h0;
        end
    endtask : sem_wr

    // The later selector loses; a tie goes to the left port.
    always @(negedge i_l_ce_b) t_l = $realtime;
    always @(negedge i_r_ce_b) t_r = $realtime;
    assign o_l_busy_b = !(match && t_r < t_l);
    assign o_r_busy_b = !(match && t_l <= t_r);
    assign o_l_int_b  = int_l;
    assign o_r_int_b  = int_r;

    // Writes land at the rising strobe; a busy port writes nothing.
    always @(posedge i_l_we_b) begin
        if (!i_l_sem_b && i_l_ce_b) begin
            sem_wr(1, i_l_addr[2:0], i_l_dq[0]);
        end else if (!i_l_ce_b && i_l_sem_b && o_l_busy_b) begin
            mem[i_l_addr] = i_l_dq;
            if (i_l_addr == 13'h1FFF) int_r = 1'h0;
        end
    end
    always @(posedge i_r_we_b) begin
        if (!i_r_sem_b && i_r_ce_b) begin
            sem_wr(2, i_r_addr[2:0], i_r_din[0]);
        end else if (!i_r_ce_b && i_r_sem_b && o_r_busy_b) begin
            mem[i_r_addr] = i_r_din;
            if (i_r_addr == 13'h1FFE) int_l = 1'h0;
        end
    end

    // Reads clear the mailbox flag and latch the semaphore value once.
    always @(posedge l_ard) if (i_l_addr == 13'h1FFE) int_l = 1'h1;
    always @(posedge r_ard) if (i_r_addr == 13'h1FFF) int_r = 1'h1;
    always @(posedge l_srd) begin
        sreg_l = {8{own[i_l_addr[2:0]] != 2'h1}};
    end
    always @(posedge r_srd) begin
        sreg_r = {8{own[i_r_addr[2:0]] != 2'h2}};
    end

    // A released left bus shows the inverse of its last level; the right bus shows the inverse of its data input.
    assign o_l_dq = l_ard ? mem[i_l_addr] : l_srd ? sreg_l :
                    i_l_dq_oe ? i_l_dq : ~last_l;
    assign o_r_dq = r_ard ? mem[i_r_addr] : r_srd ? sreg_r : ~i_r_din;
    always @(posedge i_sys_clk) last_l <= o_l_dq;
endmodule : dpr_ram_model
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench for the port controller against the RAM model.
// Assumes the controller owns the left port and the bench the right port.
`timescale 1ns/1ps
`default_nettype none
`include "dpr_cfg.svh"

module tb;
    logic i_sys_clk, i_rst_b, i_clk_en, i_cmd_valid;
    dpr_pkg::dpr_cmd_t i_cmd;
    dpr_pkg::dpr_rsp_t o_rsp;
    logic o_cmd_ready, o_rsp_valid, o_mbox_flag, o_busy_hit, o_dq_oe;
    logic o_ce_b, o_sem_b, o_we_b, o_oe_b, int_l_b, busy_l_b;
    logic [`DPR_AW-1:0] o_addr, r_addr;
    logic [`DPR_DW-1:0] o_dq, dq, r_din, r_dq, v;
    logic r_ce_b, r_sem_b, r_we_b, r_oe_b, int_r_b, busy_r_b;
    int bad_count, checks_done;

    dpr_port_ctrl #(.POLL_MAX(2)) dut (.i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b), .i_clk_en(i_clk_en), .i_cmd_valid(i_cmd_valid),
        .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready), .o_rsp_valid(o_rsp_valid),
        .o_rsp(o_rsp), .o_mbox_flag(o_mbox_flag), .o_busy_hit(o_busy_hit),
        .o_ce_b(o_ce_b), .o_sem_b(o_sem_b), .o_we_b(o_we_b), .o_oe_b(o_oe_b),
        .o_addr(o_addr), .i_dq(dq), .o_dq(o_dq), .o_dq_oe(o_dq_oe),
        .i_int_b(int_l_b), .i_busy_b(busy_l_b));
    dpr_ram_model ram (.i_sys_clk(i_sys_clk), .i_l_ce_b(o_ce_b),
        .i_l_sem_b(o_sem_b), .i_l_we_b(o_we_b), .i_l_oe_b(o_oe_b),
        .i_l_addr(o_addr), .i_l_dq(o_dq), .i_l_dq_oe(o_dq_oe), .o_l_dq(dq),
        .o_l_int_b(int_l_b), .o_l_busy_b(busy_l_b), .i_r_ce_b(r_ce_b),
        .i_r_sem_b(r_sem_b), .i_r_we_b(r_we_b), .i_r_oe_b(r_oe_b),
        .i_r_addr(r_addr), .i_r_din(r_din), .o_r_dq(r_dq),
        .o_r_int_b(int_r_b), .o_r_busy_b(busy_r_b));

    // Free-running 100 MHz clock.
    initial begin
        i_sys_clk = 1'h0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask : cyc

    // Hold the request until an edge samples ready high.
    task automatic op(input dpr_pkg::dpr_op_t opc, input logic [12:0] a,
                      input logic [7:0] d, input logic wait_rsp);
        int n;
        i_cmd_valid <= 1'h1;
        i_cmd <= '{op: opc, addr: a, data: d};
        n = 0;
        do begin cyc(1); n++; end while (o_cmd_ready !== 1'h1 && n < 50);
        i_cmd_valid <= 1'h0;
        if (o_cmd_ready !== 1'h1) begin
            chk("ready wait", 0, 1);
            give_verdict();
        end
        if (wait_rsp) waitrsp(400);
    endtask : op

    task automatic waitrsp(input int lim);
        int n;
        n = 0;
        do begin cyc(1); n++; end while (o_rsp_valid !== 1'h1 && n < lim);
        if (o_rsp_valid !== 1'h1) begin
            chk("answer wait", 0, 1);
            give_verdict();
        end
    endtask : waitrsp

    // Right-port cycles: select with strobe or output gate together; a write's strobe rises first.
    task automatic rwr(input logic sem, input logic [12:0] a,
                       input logic [7:0] d);
        r_addr <= a;
        r_din <= d;
        r_ce_b <= sem;
        r_sem_b <= !sem;
        r_we_b <= 1'h0;
        cyc(4);
        r_we_b <= 1'h1;
        cyc(1);
        {r_ce_b, r_sem_b} <= 2'h3;
        cyc(1);
    endtask : rwr

    task automatic rrd(input logic sem, input logic [12:0] a);
        r_addr <= a;
        r_ce_b <= sem;
        r_sem_b <= !sem;
        r_oe_b <= 1'h0;
        cyc(3);
        v = r_dq;
        {r_ce_b, r_sem_b, r_oe_b} <= 3'h7;
        cyc(2);
    endtask : rrd

    task automatic t_rw();
        op(dpr_pkg::DPR_OP_WR, 13'h0123, 8'h3C, 1);
        rrd(0, 13'h0123);
        chk("left write", v, 8'h3C);
        rwr(0, 13'h0123, 8'hC3);
        op(dpr_pkg::DPR_OP_RD, 13'h0123, 8'h00, 1);
        chk("left read", o_rsp.data, 8'hC3);
        op(dpr_pkg::DPR_OP_RD, 13'h0123, 8'h00, 0);
        // A low enable must freeze the read with its pins still asserted.
        i_clk_en <= 1'h0;
        cyc(20);
        chk("frozen read", {o_oe_b, o_cmd_ready, o_rsp_valid}, 3'h0);
        i_clk_en <= 1'h1;
        waitrsp(100);
        chk("back to back read", o_rsp.data, 8'hC3);
    endtask : t_rw

    task automatic t_mbox();
        rwr(0, 13'h1FFE, 8'h5E);
        cyc(5);
        chk("left flag set", o_mbox_flag, 1'h1);
        op(dpr_pkg::DPR_OP_RD, 13'h1FFE, 8'h00, 1);
        chk("left message", o_rsp.data, 8'h5E);
        cyc(5);
        chk("left flag clear", o_mbox_flag, 1'h0);
        op(dpr_pkg::DPR_OP_WR, 13'h1FFF, 8'h77, 1);
        chk("right flag set", int_r_b, 1'h0);
        rrd(0, 13'h1FFF);
        chk("right message", v, 8'h77);
        chk("right flag clear", int_r_b, 1'h1);
    endtask : t_mbox

    // The right port claims the word first, so the controller must wait.
    task automatic t_busy();
        r_addr <= 13'h0456;
        r_ce_b <= 1'h0;
        cyc(2);
        op(dpr_pkg::DPR_OP_WR, 13'h0456, 8'hAA, 0);
        cyc(30);
        chk("busy seen", o_busy_hit, 1'h1);
        chk("write held", o_cmd_ready, 1'h0);
        chk("right keeps word", busy_r_b, 1'h1);
        r_ce_b <= 1'h1;
        waitrsp(100);
        rrd(0, 13'h0456);
        chk("write after busy", v, 8'hAA);
    endtask : t_busy

    task automatic t_sem();
        for (int i = 0; i < 8; i++) rwr(1, 13'(i), 8'hFF);
        op(dpr_pkg::DPR_OP_SEM_INIT, 13'h0000, 8'hFF, 1);
        for (int i = 0; i < 8; i++) begin
            rrd(1, 13'(i));
            chk("latch free", v, 8'hFF);
        end
        op(dpr_pkg::DPR_OP_SEM_TAKE, 13'h1FFB, 8'h00, 1);
        chk("take granted", o_rsp.granted, 1'h1);
        chk("take value", o_rsp.data, 8'h00);
        rrd(1, 13'h0003);
        chk("other side", v, 8'hFF);
        rwr(1, 13'h0003, 8'h00);
        op(dpr_pkg::DPR_OP_SEM_GIVE, 13'h0003, 8'hFF, 1);
        rrd(1, 13'h0003);
        chk("handed over", v, 8'h00);
        op(dpr_pkg::DPR_OP_SEM_TAKE, 13'h0003, 8'h00, 1);
        chk("poll timeout", o_rsp.timeout, 1'h1);
        chk("poll refused", o_rsp.granted, 1'h0);
        op(dpr_pkg::DPR_OP_SEM_GIVE, 13'h0003, 8'hFF, 1);
        rwr(1, 13'h0003, 8'hFF);
        op(dpr_pkg::DPR_OP_SEM_RD, 13'h0003, 8'h00, 1);
        chk("freed", o_rsp.data, 8'hFF);
    endtask : t_sem

    // Array and semaphore selects must never be low together.
    always @(posedge i_sys_clk) begin
        if (i_rst_b === 1'h1 && o_ce_b === 1'h0) begin
            chk("selects", o_sem_b, 1'h1);
        end
    end

    // Reset, idle pin check, then the scenarios in turn.
    initial begin
        {i_rst_b, i_cmd_valid, i_clk_en} = 3'h1;
        i_cmd = '0;
        {r_ce_b, r_sem_b, r_we_b, r_oe_b} = 4'hF;
        r_addr = '0;
        r_din = '0;
        cyc(8);
        chk("idle pins", {o_ce_b, o_sem_b, o_we_b, o_oe_b, o_dq_oe}, 5'h1E);
        chk("idle ready", {o_cmd_ready, o_rsp_valid}, 2'h2);
        i_rst_b <= 1'h1;
        cyc(1);
        t_rw();
        t_mbox();
        t_busy();
        t_sem();
        give_verdict();
    end
endmodule : tb
`default_nettype wire
